// file: csel_pkg.sv
// Constants, types and register map of the command source selector
package csel_pkg;
   // Register byte offsets
   localparam logic [7:0]  OFS_START    = 8'h00;
   localparam logic [7:0]  OFS_SPEED    = 8'h04;
   localparam logic [7:0]  OFS_REMOTE   = 8'h08;
   localparam logic [7:0]  OFS_LOCAL    = 8'h0C;
   localparam logic [7:0]  OFS_UGROUP   = 8'h10;
   localparam logic [7:0]  OFS_CTRL     = 8'h14;
   localparam logic [7:0]  OFS_STATUS   = 8'h18;
   // Setting codes
   localparam logic [13:0] SET_0        = 14'h0000;
   localparam logic [13:0] SET_1        = 14'h0001;
   localparam logic [13:0] SET_2        = 14'h0002;
   localparam logic [13:0] SET_3        = 14'h0003;
   localparam logic [13:0] SET_4        = 14'h0004;
   localparam logic [13:0] SET_10       = 14'h000A;
   localparam logic [13:0] SET_AUTO     = 14'h270F;
   // Reset values
   localparam logic [13:0] RST_START    = SET_0;
   localparam logic [13:0] RST_SPEED    = SET_0;
   localparam logic [13:0] RST_REMOTE   = SET_AUTO;
   localparam logic [13:0] RST_LOCAL    = SET_AUTO;
   localparam logic [13:0] RST_UGROUP   = SET_0;
   // Command sources, one bit each
   localparam int          NSRC         = 5;
   localparam int          SRC_PANEL    = 0;
   localparam int          SRC_USB      = 1;
   localparam int          SRC_PUNIT    = 2;
   localparam int          SRC_RS485    = 3;
   localparam int          SRC_OPTION   = 4;
   // Control and status fields
   localparam int          CTRL_APPLY   = 0;
   localparam int          ST_OPTION    = 5;
   localparam int          ST_ALLOW     = 6;
   localparam int          ST_REMOTE    = 7;
   localparam int          ST_READY     = 8;
   // Input settling before capture
   localparam logic [1:0]  SETTLE_CYC   = 2'h2;

   // Request kinds
   typedef enum logic [2:0] {
      K_READ    = 3'h0,
      K_MONITOR = 3'h1,
      K_WRITE   = 3'h2,
      K_START   = 3'h3,
      K_FREQ    = 3'h4
   } csel_kind_e;

   // One request from one source
   typedef struct packed {
      logic       valid;
      csel_kind_e kind;
      logic       modbus;
   } csel_req_s;

   // Active configuration captured at reset
   typedef struct packed {
      logic [13:0] start_src;
      logic [13:0] speed_src;
      logic [13:0] remote_src;
      logic [13:0] local_src;
      logic        option;
   } csel_cfg_s;
endpackage

// file: csel_src_model.sv
// Far-side command sources: panel, USB, param unit, RS-485, option
`timescale 1ns/1ps
module csel_src_model (
   // Clock
   input  wire logic                 i_clock,
   // Verdicts from the selector
   input  wire logic [4:0]           i_accept,
   input  wire logic [4:0]           i_reject,
   // Requests and presence pins
   output csel_pkg::csel_req_s [4:0] o_req,
   output logic                      o_option,
   output logic                      o_usb,
   output logic                      o_punit
);
   import csel_pkg::*;

   // Nothing plugged, no request at time zero
   initial begin
      o_req    = '0;
      o_option = 1'b0;
      o_usb    = 1'b0;
      o_punit  = 1'b0;
   end

   // One-cycle request, verdict pair {accept, reject} one cycle later
   task automatic send(input int s, input csel_kind_e k, input logic mb,
                       output logic [1:0] v);
      @(posedge i_clock);
      o_req[s] <= {1'b1, k, mb};
      @(posedge i_clock);
      o_req[s] <= '0;
      #1;
      v = {i_accept[s], i_reject[s]};
   endtask

   // Plug or pull devices, then let the synchronisers settle
   task automatic fit(input logic opt, input logic usb, input logic pu);
      @(posedge i_clock);
      o_option <= opt;
      o_usb    <= usb;
      o_punit  <= pu;
      repeat (4) @(posedge i_clock);
   endtask
endmodule

// file: csel_top.sv
// Command source selector with AHB-Lite settings registers
//
// How it works
// [RULE_01] Non-Modbus reads and monitoring pass from any source in any mode.
// [RULE_02] Writes, starts, frequencies only from the selected source.
// [RULE_03] Start setting 0 comm, 1 terminals; reset 0.
// [RULE_04] Speed 0 comm, 1 terminal 2 only, 2 comm only; reset 0.
// [RULE_05] Remote 0: option card is the only remote source.
// [RULE_06] Remote 2: unit RS-485 is the remote source.
// [RULE_07] Remote 9999: unit connector, or option card when fitted.
// [RULE_08] Remote 9999 with option refuses unit RS-485 commands.
// [RULE_09] Local 2 unit connector, 3 USB, 4 panel.
// [RULE_10] Local 9999: USB, then parameter unit, then panel.
// [RULE_11] Local 9999: RS-485 traffic never becomes local source.
// [RULE_12] Both 2: local wins, remote refused without option.
// [RULE_13] Remote entry refused when its source is an absent option.
// [RULE_14] New settings act only after reset.
// [RULE_15] Modbus refused locally, needs remote setting 2.
// [RULE_16] Remote and local settings always writable.
// [RULE_17] Start and speed settings need user group 0 or an option.
// [RULE_18] Remote 2, local 3 or 4: RS-485 is remote source.
// [RULE_19] Remote 10: panel key and mode input switch directly.
// [RULE_20] Resolved settings and option held from reset on.
`timescale 1ns/1ps
module csel_top (
   // Clock and reset
   input  wire logic                   i_clock,
   input  wire logic                   i_rst_n,
   // AHB-Lite slave
   input  wire logic                   i_hsel,
   input  wire logic [31:0]            i_haddr,
   input  wire logic [1:0]             i_htrans,
   input  wire logic                   i_hwrite,
   input  wire logic [2:0]             i_hsize,
   input  wire logic [31:0]            i_hwdata,
   input  wire logic                   i_hready,
   output logic      [31:0]            o_hrdata,
   output logic                        o_hreadyout,
   output logic                        o_hresp,
   // Presence pins
   input  wire logic                   i_option_fitted,
   input  wire logic                   i_usb_connected,
   input  wire logic                   i_punit_connected,
   // Mode handling
   input  wire logic                   i_remote_mode,
   input  wire logic                   i_to_remote_req,
   input  wire logic                   i_panel_mode_key,
   input  wire logic                   i_mode_switch_input,
   output logic                        o_remote_allow,
   output logic                        o_remote_grant,
   output logic                        o_remote_refuse,
   output logic                        o_direct_switch,
   // Requests per source and verdicts
   input  csel_pkg::csel_req_s [4:0]   i_req,
   output logic      [4:0]             o_accept,
   output logic      [4:0]             o_reject,
   // Resolved routing
   output logic      [4:0]             o_cmd_src,
   output logic                        o_start_terminal,
   output logic                        o_freq_comm_valid,
   output logic                        o_freq_term2_valid,
   output logic                        o_ready
);
   import csel_pkg::*;

   // Capture sequence states
   typedef enum logic [2:0] {
      CS_SETTLE  = 3'b001,
      CS_CAPTURE = 3'b010,
      CS_RUN     = 3'b100
   } csel_cap_e;

   // Remote source for a configuration
   function automatic logic [4:0] remote_tgt(input csel_cfg_s c);
      logic [4:0] t;
      t = 5'h00;
      if ((c.remote_src == SET_0) ||
          ((c.remote_src == SET_2) && (c.local_src == SET_2)) ||
          ((c.remote_src != SET_2) && c.option)) begin
         t[SRC_OPTION] = 1'b1;
      end else begin
         t[SRC_RS485] = 1'b1;
      end
      return t;
   endfunction

   // Legal value for a setting at an offset
   function automatic logic legal(input logic [7:0] ofs,
                                  input logic [13:0] v);
      logic ok;
      ok = 1'b0;
      unique case (ofs)
         OFS_START:  ok = (v == SET_0) || (v == SET_1);
         OFS_SPEED:  ok = (v <= SET_2);
         OFS_REMOTE: ok = (v == SET_0) || (v == SET_2) ||
                          (v == SET_10) || (v == SET_AUTO);
         OFS_LOCAL:  ok = ((v >= SET_2) && (v <= SET_4)) ||
                          (v == SET_AUTO);
         OFS_UGROUP: ok = 1'b1;
         default:    ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Pin synchronisers
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic       msw1_r;
   logic       msw2_r;
   logic       msw3_r;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         msw1_r  <= 1'b0;
         msw2_r  <= 1'b0;
         msw3_r  <= 1'b0;
      end else begin
         sync1_r <= {i_punit_connected, i_usb_connected, i_option_fitted};
         sync2_r <= sync1_r;
         msw1_r  <= i_mode_switch_input;
         msw2_r  <= msw1_r;
         msw3_r  <= msw2_r;
      end
   end
   logic opt_s;
   logic usb_s;
   logic punit_s;
   assign opt_s   = sync2_r[0];
   assign usb_s   = sync2_r[1];
   assign punit_s = sync2_r[2];

   // Software setting registers
   logic [13:0] start_r, start_nxt;
   logic [13:0] speed_r, speed_nxt;
   logic [13:0] remote_r, remote_nxt;
   logic [13:0] local_r, local_nxt;
   logic [13:0] ugroup_r, ugroup_nxt;
   logic        apply_r, apply_nxt;
   // Bus data phase state
   logic        dp_wr_r, dp_wr_nxt;
   logic        dp_rd_r, dp_rd_nxt;
   logic [7:0]  dp_ofs_r, dp_ofs_nxt;
   // Capture state
   csel_cap_e   cap_r, cap_nxt;
   logic [1:0]  cnt_r, cnt_nxt;
   csel_cfg_s   act_r, act_nxt;

   // Bus decode and register writes
   always_comb begin
      logic [13:0] wv;
      logic        lock;
      wv         = i_hwdata[13:0];
      lock       = (ugroup_r != SET_0) && !opt_s;
      dp_wr_nxt  = 1'b0;
      dp_rd_nxt  = 1'b0;
      dp_ofs_nxt = dp_ofs_r;
      start_nxt  = start_r;
      speed_nxt  = speed_r;
      remote_nxt = remote_r;
      local_nxt  = local_r;
      ugroup_nxt = ugroup_r;
      apply_nxt  = 1'b0;
      if (i_hsel && i_hready && i_htrans[1]) begin
         dp_wr_nxt  = i_hwrite;
         dp_rd_nxt  = !i_hwrite;
         dp_ofs_nxt = {i_haddr[7:2], 2'b00};
      end
      if (dp_wr_r && legal(dp_ofs_r, wv)) begin
         unique case (dp_ofs_r)
            // [RULE_17] Guarded writes
            OFS_START:  if (!lock) start_nxt = wv;
            OFS_SPEED:  if (!lock) speed_nxt = wv;
            // [RULE_16] Always writable
            OFS_REMOTE: remote_nxt = wv;
            OFS_LOCAL:  local_nxt  = wv;
            OFS_UGROUP: ugroup_nxt = wv;
            default:    ;
         endcase
      end
      if (dp_wr_r && (dp_ofs_r == OFS_CTRL)) begin
         apply_nxt = i_hwdata[CTRL_APPLY];
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_r  <= RST_START;
         speed_r  <= RST_SPEED;
         remote_r <= RST_REMOTE;
         local_r  <= RST_LOCAL;
         ugroup_r <= RST_UGROUP;
         apply_r  <= 1'b0;
         dp_wr_r  <= 1'b0;
         dp_rd_r  <= 1'b0;
         dp_ofs_r <= 8'h00;
      end else begin
         start_r  <= start_nxt;
         speed_r  <= speed_nxt;
         remote_r <= remote_nxt;
         local_r  <= local_nxt;
         ugroup_r <= ugroup_nxt;
         apply_r  <= apply_nxt;
         dp_wr_r  <= dp_wr_nxt;
         dp_rd_r  <= dp_rd_nxt;
         dp_ofs_r <= dp_ofs_nxt;
      end
   end

   // Capture of the active configuration
   always_comb begin
      cap_nxt = cap_r;
      cnt_nxt = cnt_r;
      act_nxt = act_r;
      unique case (cap_r)
         CS_SETTLE: begin
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == SETTLE_CYC) begin
               cap_nxt = CS_CAPTURE;
            end
         end
         CS_CAPTURE: begin
            // [RULE_20] Latch resolved settings
            act_nxt = '{start_r, speed_r, remote_r, local_r, opt_s};
            cap_nxt = CS_RUN;
         end
         CS_RUN: begin
            // [RULE_14] Reload only on reset
            if (apply_r) begin
               cap_nxt = CS_SETTLE;
               cnt_nxt = 2'h0;
            end
         end
         default: begin
            cap_nxt = CS_SETTLE;
            cnt_nxt = 2'h0;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cap_r <= CS_SETTLE;
         cnt_r <= 2'h0;
         act_r <= '{RST_START, RST_SPEED, RST_REMOTE, RST_LOCAL, 1'b0};
      end else begin
         cap_r <= cap_nxt;
         cnt_r <= cnt_nxt;
         act_r <= act_nxt;
      end
   end

   // Source resolution
   logic [4:0] rem_t;
   logic [4:0] loc_t;
   logic [4:0] src_en;
   logic       allow;
   logic       run;
   assign run = (cap_r == CS_RUN);
   // [RULE_05] [RULE_06] [RULE_07] [RULE_18] Remote source
   assign rem_t = remote_tgt(act_r);
   // [RULE_12] [RULE_13] Absent option blocks remote
   assign allow = run && (rem_t != 5'h00) &&
                  !(rem_t[SRC_OPTION] && !act_r.option);

   always_comb begin
      loc_t = 5'h00;
      if (act_r.local_src == SET_2) begin
         // [RULE_09] Unit connector both ways
         loc_t[SRC_PUNIT] = 1'b1;
         loc_t[SRC_RS485] = 1'b1;
      end else if (act_r.local_src == SET_3) begin
         loc_t[SRC_USB] = 1'b1;
      end else if (act_r.local_src == SET_4) begin
         loc_t[SRC_PANEL] = 1'b1;
      end else if (usb_s) begin
         // [RULE_10] [RULE_11] Priority, RS-485 excluded
         loc_t[SRC_USB] = 1'b1;
      end else if (punit_s) begin
         loc_t[SRC_PUNIT] = 1'b1;
      end else begin
         loc_t[SRC_PANEL] = 1'b1;
      end
   end
   // [RULE_08] Remote mode: only the resolved remote source drives; local mode: the local source
   assign src_en = !run ? 5'h00 : (i_remote_mode ? rem_t : loc_t);

   // Per-source verdicts and mode answers
   logic [4:0] acc_r, acc_nxt;
   logic [4:0] rej_r, rej_nxt;
   logic [4:0] src_r;
   logic       grant_r, grant_nxt;
   logic       refuse_r, refuse_nxt;
   logic       dsw_r, dsw_nxt;
   logic       allow_r;
   always_comb begin
      logic ok;
      logic cmd;
      ok  = 1'b0;
      cmd = 1'b0;
      acc_nxt = 5'h00;
      rej_nxt = 5'h00;
      for (int i = 0; i < NSRC; i++) begin
         cmd = (i_req[i].kind == K_WRITE) || (i_req[i].kind == K_START) ||
               (i_req[i].kind == K_FREQ);
         // [RULE_01] Reads pass unless the Modbus check below refuses them
         ok  = (i_req[i].kind == K_READ) || (i_req[i].kind == K_MONITOR);
         // [RULE_02] Commands from selected source
         if (cmd) begin
            ok = src_en[i];
         end
         // [RULE_03] Start from terminals
         if (i_remote_mode && (i_req[i].kind == K_START) &&
             (act_r.start_src == SET_1)) begin
            ok = 1'b0;
         end
         // [RULE_04] Comm frequency ignored
         if (i_remote_mode && (i_req[i].kind == K_FREQ) &&
             (act_r.speed_src == SET_1)) begin
            ok = 1'b0;
         end
         // [RULE_15] Modbus needs remote setting 2
         if (i_req[i].modbus && (!i_remote_mode ||
             (act_r.remote_src != SET_2))) begin
            ok = 1'b0;
         end
         if (i_req[i].valid) begin
            acc_nxt[i] = ok;
            rej_nxt[i] = !ok;
         end
      end
      // [RULE_13] Answer a remote request
      grant_nxt  = i_to_remote_req && allow;
      refuse_nxt = i_to_remote_req && !allow;
      // [RULE_19] Direct switch under setting 10
      dsw_nxt = run && (act_r.remote_src == SET_10) &&
                (i_panel_mode_key || (msw2_r && !msw3_r));
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acc_r    <= 5'h00;
         rej_r    <= 5'h00;
         src_r    <= 5'h00;
         grant_r  <= 1'b0;
         refuse_r <= 1'b0;
         dsw_r    <= 1'b0;
         allow_r  <= 1'b0;
      end else begin
         acc_r    <= acc_nxt;
         rej_r    <= rej_nxt;
         src_r    <= src_en;
         grant_r  <= grant_nxt;
         refuse_r <= refuse_nxt;
         dsw_r    <= dsw_nxt;
         allow_r  <= allow;
      end
   end

   // Read data mux in the data phase
   always_comb begin
      o_hrdata = 32'h0000_0000;
      if (dp_rd_r) begin
         unique case (dp_ofs_r)
            OFS_START:  o_hrdata[13:0] = start_r;
            OFS_SPEED:  o_hrdata[13:0] = speed_r;
            OFS_REMOTE: o_hrdata[13:0] = remote_r;
            OFS_LOCAL:  o_hrdata[13:0] = local_r;
            OFS_UGROUP: o_hrdata[13:0] = ugroup_r;
            OFS_STATUS: begin
               o_hrdata[4:0]       = src_r;
               o_hrdata[ST_OPTION] = act_r.option;
               o_hrdata[ST_ALLOW]  = allow_r;
               o_hrdata[ST_REMOTE] = i_remote_mode;
               o_hrdata[ST_READY]  = run;
            end
            default:    o_hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Outputs
   assign o_hreadyout        = 1'b1;
   assign o_hresp            = 1'b0;
   assign o_accept           = acc_r;
   assign o_reject           = rej_r;
   assign o_cmd_src          = src_r;
   assign o_remote_allow     = allow_r;
   assign o_remote_grant     = grant_r;
   assign o_remote_refuse    = refuse_r;
   assign o_direct_switch    = dsw_r;
   assign o_start_terminal   = (act_r.start_src == SET_1);
   assign o_freq_comm_valid  = (act_r.speed_src != SET_1);
   assign o_freq_term2_valid = (act_r.speed_src != SET_2);
   assign o_ready            = run;
endmodule

// file: csel_top_asserts.sv
// Port-level checks of the command source selector
`timescale 1ns/1ps
module csel_top_asserts (
   // Clock and reset
   input wire logic                     i_clock,
   input wire logic                     i_rst_n,
   // Mode handling
   input wire logic                     i_remote_mode,
   input wire logic                     i_to_remote_req,
   input wire logic                     i_panel_mode_key,
   input wire logic                     i_mode_switch_input,
   input wire logic                     o_remote_allow,
   input wire logic                     o_remote_grant,
   input wire logic                     o_remote_refuse,
   input wire logic                     o_direct_switch,
   // Requests and verdicts
   input wire csel_pkg::csel_req_s [4:0] i_req,
   input wire logic [4:0]               o_accept,
   input wire logic [4:0]               o_reject,
   // Resolved routing
   input wire logic [4:0]               o_cmd_src,
   input wire logic                     o_start_terminal,
   input wire logic                     o_freq_comm_valid,
   input wire logic                     o_freq_term2_valid,
   input wire logic                     o_ready
);
   import csel_pkg::*;
   logic [4:0] vld;
   logic [4:0] rdv;
   logic [4:0] cmdv;
   logic [4:0] mbl;

   // Request classes per source
   always_comb begin
      for (int k = 0; k < NSRC; k++) begin
         vld[k]  = i_req[k].valid;
         rdv[k]  = vld[k] && !i_req[k].modbus &&
                   (i_req[k].kind inside {K_READ, K_MONITOR});
         cmdv[k] = vld[k] && (i_req[k].kind inside {K_WRITE, K_START, K_FREQ});
         mbl[k]  = vld[k] && i_req[k].modbus && !i_remote_mode;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   AST_VERDICT: assert property (
      (o_accept | o_reject) == $past(vld) && (o_accept & o_reject) == 5'h00)
      else $error("verdict not one per request");
   AST_READ_OK: assert property (
      rdv != 5'h00 |=> (o_accept & $past(rdv)) == $past(rdv))
      else $error("read refused");
   AST_CMD_SEL: assert property (
      cmdv != 5'h00 |=> (o_accept & $past(cmdv) & ~$past(o_cmd_src)) == 5'h00)
      else $error("command from unselected source");
   AST_NOT_READY: assert property (
      !o_ready && cmdv != 5'h00 |=> (o_accept & $past(cmdv)) == 5'h00)
      else $error("command before capture");
   AST_MODBUS_LOCAL: assert property (
      mbl != 5'h00 |=> (o_reject & $past(mbl)) == $past(mbl))
      else $error("modbus taken locally");
   AST_REQ_GRANT: assert property (
      (o_remote_grant | o_remote_refuse) == $past(i_to_remote_req))
      else $error("grant or refuse without request");
   AST_GRANT_ALLOW: assert property (
      i_to_remote_req |=> o_remote_grant == $past(o_remote_allow))
      else $error("grant ignores allow");
   AST_ALLOW_READY: assert property (
      !o_ready && !$past(o_ready) |-> !o_remote_allow)
      else $error("remote allowed without config");
   AST_HELD_CFG: assert property (
      o_ready && $past(o_ready) |->
      $stable({o_start_terminal, o_freq_comm_valid, o_freq_term2_valid}))
      else $error("routing changed without reset");
   AST_DIRECT: assert property (
      o_direct_switch |->
      $past(i_panel_mode_key) || $past(i_mode_switch_input, 2))
      else $error("direct switch without cause");

   // Main scenarios reached
   COV_GRANT: cover property (o_remote_grant);
   COV_DIRECT: cover property (o_direct_switch);
   COV_OPTION: cover property (o_accept[SRC_OPTION]);
endmodule

bind csel_top csel_top_asserts i_csel_top_asserts (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_remote_mode(i_remote_mode),
   .i_to_remote_req(i_to_remote_req), .i_panel_mode_key(i_panel_mode_key),
   .i_mode_switch_input(i_mode_switch_input), .o_remote_allow(o_remote_allow),
   .o_remote_grant(o_remote_grant), .o_remote_refuse(o_remote_refuse),
   .o_direct_switch(o_direct_switch), .i_req(i_req), .o_accept(o_accept),
   .o_reject(o_reject), .o_cmd_src(o_cmd_src),
   .o_start_terminal(o_start_terminal), .o_freq_comm_valid(o_freq_comm_valid),
   .o_freq_term2_valid(o_freq_term2_valid), .o_ready(o_ready)
);

// file: testbench.sv
// Self-checking bench for the command source selector
`timescale 1ns/1ps
module testbench;
   import csel_pkg::*;
   logic                clock = 1'b0;
   logic                rst_n, hsel, hwrite, tor, pkey, mswitch, rmode;
   logic [31:0]         haddr, hwdata;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   wire logic [31:0]    hrdata;
   wire logic           hrdy, hresp, allow, grant, refuse, dsw, ready;
   wire logic [4:0]     accept, reject, cmd_src;
   wire csel_req_s [4:0] req;
   wire logic           opt, usb, pu;
   int                  bad_count = 0;
   int                  cmp_count = 0;
   logic [13:0]         lset [3] = '{SET_2, SET_3, SET_4};
   int                  lsrc [3] = '{SRC_PUNIT, SRC_USB, SRC_PANEL};

   // Clock
   always #2.5 clock = ~clock;

   csel_top i_csel_top (
      .i_clock(clock), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
      .o_hreadyout(hrdy), .o_hresp(hresp), .i_option_fitted(opt),
      .i_usb_connected(usb), .i_punit_connected(pu), .i_remote_mode(rmode),
      .i_to_remote_req(tor), .i_panel_mode_key(pkey),
      .i_mode_switch_input(mswitch), .o_remote_allow(allow),
      .o_remote_grant(grant), .o_remote_refuse(refuse),
      .o_direct_switch(dsw), .i_req(req), .o_accept(accept),
      .o_reject(reject), .o_cmd_src(cmd_src), .o_start_terminal(),
      .o_freq_comm_valid(), .o_freq_term2_valid(), .o_ready(ready)
   );

   csel_src_model i_csel_src_model (
      .i_clock(clock), .i_accept(accept), .i_reject(reject), .o_req(req),
      .o_option(opt), .o_usb(usb), .o_punit(pu)
   );

   // Verdict and end of run
   task automatic summarize;
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic tmo;
      bad_count++;
      summarize();
   endtask

   task automatic chk(input string n, input logic [31:0] got,
                      input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, exp, got);
      end
   endtask

   // Hold a bus phase until hready is seen at a rising edge
   task automatic hold(output logic [31:0] q);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         q = hrdata;
         n++;
         if (n > 50) tmo();
      end while (hrdy !== 1'b1);
   endtask

   // One single AHB-Lite word transfer
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      htrans <= 2'h2;
      haddr  <= 32'(a);
      hwrite <= w;
      hold(q);
      htrans <= 2'h0;
      hwdata <= d;
      hold(q);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk("register", q, e);
   endtask

   // Request from source s, e set when acceptance expected
   task automatic rq(input int s, input csel_kind_e k, input logic mb,
                     input logic e);
      logic [1:0] v;
      i_csel_src_model.send(s, k, mb, v);
      chk("verdict", 32'(v), e ? 32'h2 : 32'h1);
   endtask

   task automatic fit(input logic o, input logic u, input logic p);
      i_csel_src_model.fit(o, u, p);
   endtask

   task automatic wrdy(input logic v);
      int n;
      n = 0;
      while (ready !== v) begin
         @(posedge clock);
         #1;
         n++;
         if (n > 40) tmo();
      end
   endtask

   // Soft reset so new settings are captured
   task automatic apply;
      wr(OFS_CTRL, 32'h1);
      wrdy(1'b0);
      wrdy(1'b1);
   endtask

   task automatic cfg(input logic [13:0] r, input logic [13:0] l);
      wr(OFS_REMOTE, 32'(r));
      wr(OFS_LOCAL, 32'(l));
      apply();
   endtask

   task automatic md(input logic v);
      @(posedge clock);
      rmode <= v;
   endtask

   // Remote entry request, e set when grant expected
   task automatic rmq(input logic e);
      @(posedge clock);
      tor <= 1'b1;
      @(posedge clock);
      tor <= 1'b0;
      #1;
      chk("grant", {30'h00000000, grant, refuse}, e ? 32'h2 : 32'h1);
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      hsel = 1'b1;
      hwrite = 1'b0;
      tor = 1'b0;
      pkey = 1'b0;
      mswitch = 1'b0;
      rmode = 1'b0;
      haddr = '0;
      hwdata = '0;
      htrans = 2'h0;
      hsize = 3'h2;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      wrdy(1'b1);
      rd(OFS_START, 32'h0);
      rd(OFS_SPEED, 32'h0);
      rd(OFS_REMOTE, 32'h270F);
      rd(OFS_LOCAL, 32'h270F);
      rd(8'h1C, 32'h0);
      rq(SRC_PANEL, K_WRITE, 1'b0, 1'b1);
      rq(SRC_RS485, K_START, 1'b0, 1'b0);
      for (int s = 0; s < NSRC; s++) rq(s, K_MONITOR, 1'b0, 1'b1);
      fit(1'b0, 1'b1, 1'b1);
      rq(SRC_USB, K_WRITE, 1'b0, 1'b1);
      rq(SRC_PUNIT, K_WRITE, 1'b0, 1'b0);
      fit(1'b0, 1'b0, 1'b1);
      rq(SRC_PUNIT, K_START, 1'b0, 1'b1);
      fit(1'b0, 1'b0, 1'b0);
      rmq(1'b1);
      md(1'b1);
      rq(SRC_RS485, K_START, 1'b0, 1'b1);
      rq(SRC_RS485, K_READ, 1'b1, 1'b0);
      md(1'b0);
      wr(OFS_LOCAL, 32'h3);
      rq(SRC_PANEL, K_WRITE, 1'b0, 1'b1);
      fit(1'b1, 1'b0, 1'b0);
      cfg(SET_AUTO, SET_AUTO);
      md(1'b1);
      rq(SRC_RS485, K_WRITE, 1'b0, 1'b0);
      rq(SRC_RS485, K_FREQ, 1'b0, 1'b0);
      rq(SRC_OPTION, K_START, 1'b0, 1'b1);
      wr(OFS_REMOTE, 32'h2);
      rd(OFS_REMOTE, 32'h2);
      rq(SRC_RS485, K_WRITE, 1'b0, 1'b0);
      apply();
      rq(SRC_RS485, K_WRITE, 1'b0, 1'b1);
      rq(SRC_RS485, K_FREQ, 1'b1, 1'b1);
      md(1'b0);
      rq(SRC_PANEL, K_WRITE, 1'b1, 1'b0);
      for (int i = 0; i < 3; i++) begin
         cfg(SET_2, lset[i]);
         rq(lsrc[i], K_START, 1'b0, 1'b1);
      end
      md(1'b1);
      rq(SRC_RS485, K_START, 1'b0, 1'b1);
      md(1'b0);
      fit(1'b0, 1'b0, 1'b0);
      cfg(SET_2, SET_2);
      rmq(1'b0);
      cfg(SET_0, SET_4);
      rmq(1'b0);
      fit(1'b1, 1'b0, 1'b0);
      apply();
      rmq(1'b1);
      md(1'b1);
      rq(SRC_OPTION, K_START, 1'b0, 1'b1);
      rq(SRC_RS485, K_START, 1'b0, 1'b0);
      md(1'b0);
      fit(1'b0, 1'b0, 1'b0);
      wr(OFS_UGROUP, 32'h1);
      wr(OFS_START, 32'h1);
      rd(OFS_START, 32'h0);
      wr(OFS_REMOTE, 32'hA);
      rd(OFS_REMOTE, 32'hA);
      fit(1'b1, 1'b0, 1'b0);
      wr(OFS_START, 32'h1);
      wr(OFS_SPEED, 32'h1);
      rd(OFS_START, 32'h1);
      rd(OFS_SPEED, 32'h1);
      apply();
      md(1'b1);
      rq(SRC_OPTION, K_START, 1'b0, 1'b0);
      rq(SRC_OPTION, K_FREQ, 1'b0, 1'b0);
      rq(SRC_OPTION, K_WRITE, 1'b0, 1'b1);
      md(1'b0);
      @(posedge clock);
      pkey <= 1'b1;
      @(posedge clock);
      pkey <= 1'b0;
      #1;
      chk("direct_key", 32'(dsw), 32'h1);
      @(posedge clock);
      mswitch <= 1'b1;
      // Two sync stages, edge detect, then the output flop
      repeat (3) @(posedge clock);
      #1;
      chk("direct_pin", 32'(dsw), 32'h1);
      summarize();
   end
endmodule
